// [rtl/cmf_core.sv]
// mailbox scheduler, receive fifos, stamp counter, test modes, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module cmf_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic bit_tick,
  input wire logic bus_idle,
  input wire logic sof_sample,
  input wire logic core_tx_bit,
  output logic core_rx_bit,
  output logic ignore_ack,
  output logic tx_active,
  output logic [1:0] tx_mailbox,
  output logic [31:0] tx_id,
  output logic [31:0] tx_len,
  output logic [31:0] tx_data_lo,
  output logic [31:0] tx_data_hi,
  input wire logic tx_ok,
  input wire logic tx_arb_lost,
  input wire logic tx_error,
  input wire logic rx_frame_ok,
  input wire logic rx_filter_pass,
  input wire logic rx_fifo_sel,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [31:0] rx_data_lo,
  input wire logic [31:0] rx_data_hi,
  output logic bus_tx_pin,
  input wire logic bus_rx_pin,
  input wire logic debug_halt,
  input wire logic debug_stop_first_controller,
  output logic frozen,
  output logic irq_fifo0,
  output logic irq_fifo1
);
  logic [6:0] ctrl;
  logic [5:0] ien;
  logic [15:0] timer;
  logic [15:0] sof_stamp;
  logic [31:0] tstat;
  cmf_pkg::cmf_mb_e mb_state [3];
  logic [31:0] mb_word [3][4];
  logic [1:0] rank [3];
  logic [2:0] cancel_seen;
  logic aw_full, w_full;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_en, rd_ok;
  logic [31:0] rd_word;
  logic [2:0] cand, done_ev, ok_ev, arb_ev, err_ev, send_wr, cancel_wr;
  logic [1:0] win;
  logic win_ok, start, result, rx_store;
  logic [127:0] fifo_head [2];
  logic [1:0] fifo_cnt [2];
  logic [1:0] fifo_full, fifo_ovr, fifo_rel, fifo_clr_full, fifo_clr_ovr, fifo_irq;
  logic [31:0] wr_bits;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = val[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic is_mb(input logic [7:0] a);
    return a[7:6] == cmf_pkg::OFS_MB_HI && a[5:4] != 2'h3;
  endfunction

  function automatic logic beats(input logic [28:0] id_a, input logic [1:0] r_a,
                                 input logic [28:0] id_b, input logic [1:0] r_b,
                                 input logic by_order);
    return by_order ? (r_a > r_b) : (id_a < id_b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken in either order, one at a time
  assign wr_en = aw_full && w_full && !s_axi_bvalid;
  assign wr_bits = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cmf_pkg::RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr <= cmf_pkg::OFS_TIMER || is_mb(wr_addr)) ?
          cmf_pkg::RESP_OKAY : cmf_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (is_mb(s_axi_araddr)) begin
      rd_word = mb_word[s_axi_araddr[5:4]][s_axi_araddr[3:2]];
    end else if (s_axi_araddr[7:5] == cmf_pkg::OFS_FO_HI) begin
      rd_word = fifo_head[s_axi_araddr[4]][s_axi_araddr[3:2]*32 +: 32];
    end else begin
      case (s_axi_araddr)
        cmf_pkg::OFS_CTRL: rd_word = {25'h0, ctrl};
        cmf_pkg::OFS_TSTAT: rd_word = tstat;
        cmf_pkg::OFS_TREQ: rd_word = {26'h0, mb_state[2], mb_state[1], mb_state[0]};
        cmf_pkg::OFS_IEN: rd_word = {26'h0, ien};
        cmf_pkg::OFS_FIFO0: rd_word = {27'h0, fifo_ovr[0], fifo_full[0], 1'b0, fifo_cnt[0]};
        cmf_pkg::OFS_FIFO1: rd_word = {27'h0, fifo_ovr[1], fifo_full[1], 1'b0, fifo_cnt[1]};
        cmf_pkg::OFS_TIMER: rd_word = {16'h0, timer};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cmf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? cmf_pkg::RESP_OKAY : cmf_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and enable registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= cmf_pkg::CTRL_RESET;
      ien <= 6'h00;
    end else if (wr_en && wr_addr == cmf_pkg::OFS_CTRL) begin
      ctrl <= wr_bits[6:0] | (ctrl & ~{7{wr_strb[0]}});
    end else if (wr_en && wr_addr == cmf_pkg::OFS_IEN) begin
      ien <= wr_bits[5:0] | (ien & ~{6{wr_strb[0]}});
    end
  end

  // freeze only when the halt is both enabled in the debug unit and locally
  always_ff @(posedge clk) begin
    if (reset) begin
      frozen <= 1'b0;
    end else begin
      frozen <= debug_halt && debug_stop_first_controller &&
        ctrl[cmf_pkg::CTRL_FREEZE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin routing; registered, so the core sees its own bits one cycle late
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_tx_pin <= 1'b1;
      core_rx_bit <= 1'b1;
      ignore_ack <= 1'b0;
    end else begin
      bus_tx_pin <= ctrl[cmf_pkg::CTRL_LISTEN] ? 1'b1 : core_tx_bit;
      ignore_ack <= ctrl[cmf_pkg::CTRL_LOOP];
      if (ctrl[cmf_pkg::CTRL_LOOP]) begin
        core_rx_bit <= core_tx_bit;
      end else if (ctrl[cmf_pkg::CTRL_LISTEN]) begin
        core_rx_bit <= bus_rx_pin && core_tx_bit;
      end else begin
        core_rx_bit <= bus_rx_pin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stamp counter: wraps at sixteen bits, captured at start of frame
  always_ff @(posedge clk) begin
    if (reset) begin
      timer <= 16'h0000;
      sof_stamp <= 16'h0000;
    end else begin
      if (ctrl[cmf_pkg::CTRL_TTIME] && bit_tick && !frozen) begin
        timer <= timer + 16'h0001;
      end
      if (sof_sample) begin
        sof_stamp <= timer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit scheduling
  always_comb begin
    win = 2'h0;
    win_ok = 1'b0;
    for (int i = 0; i < 3; i++) begin
      send_wr[i] = wr_en && wr_addr == cmf_pkg::OFS_TREQ && wr_bits[i];
      cancel_wr[i] = wr_en && wr_addr == cmf_pkg::OFS_TREQ && wr_bits[cmf_pkg::TREQ_CANCEL + i];
      cand[i] = (mb_state[i] == cmf_pkg::MB_PENDING || mb_state[i] == cmf_pkg::MB_SCHED)
        && !cancel_wr[i];
      if (cand[i] && (!win_ok || beats(mb_word[i][0][28:0], rank[i],
          mb_word[win][0][28:0], rank[win], ctrl[cmf_pkg::CTRL_QORDER]))) begin
        win = 2'(i);
        win_ok = 1'b1;
      end
    end
  end

  // listen-only never starts a frame; frozen core holds back too
  assign start = win_ok && mb_state[win] == cmf_pkg::MB_SCHED && bus_idle && !tx_active &&
    !ctrl[cmf_pkg::CTRL_LISTEN] && !frozen;
  assign result = tx_active && (tx_ok || tx_arb_lost || tx_error);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ok_ev[i] = result && tx_mailbox == 2'(i) && tx_ok;
      arb_ev[i] = result && tx_mailbox == 2'(i) && !tx_ok && tx_arb_lost;
      err_ev[i] = result && tx_mailbox == 2'(i) && !tx_ok && tx_error;
      done_ev[i] = ok_ev[i] || ((arb_ev[i] || err_ev[i]) &&
        (ctrl[cmf_pkg::CTRL_SINGLE] || cancel_seen[i] || cancel_wr[i])) ||
        (cancel_wr[i] && (mb_state[i] == cmf_pkg::MB_PENDING ||
        mb_state[i] == cmf_pkg::MB_SCHED));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        mb_state[i] <= cmf_pkg::MB_EMPTY;
        rank[i] <= 2'h0;
      end
      cancel_seen <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (send_wr[i] && mb_state[i] == cmf_pkg::MB_EMPTY) begin
          rank[i] <= 2'h0;
        end else if (mb_state[i] != cmf_pkg::MB_EMPTY && |send_wr && rank[i] != 2'h3) begin
          rank[i] <= rank[i] + 2'h1;
        end
        case (mb_state[i])
          cmf_pkg::MB_EMPTY: begin
            cancel_seen[i] <= 1'b0;
            if (send_wr[i]) mb_state[i] <= cmf_pkg::MB_PENDING;
          end
          cmf_pkg::MB_PENDING, cmf_pkg::MB_SCHED: begin
            if (cancel_wr[i]) begin
              mb_state[i] <= cmf_pkg::MB_EMPTY;
            end else if (start && win == 2'(i)) begin
              mb_state[i] <= cmf_pkg::MB_SEND;
            end else if (win_ok && win == 2'(i) && !tx_active) begin
              mb_state[i] <= cmf_pkg::MB_SCHED;
            end else begin
              mb_state[i] <= cmf_pkg::MB_PENDING;
            end
          end
          cmf_pkg::MB_SEND: begin
            if (cancel_wr[i]) cancel_seen[i] <= 1'b1;
            if (done_ev[i]) begin
              mb_state[i] <= cmf_pkg::MB_EMPTY;
            end else if (arb_ev[i] || err_ev[i]) begin
              mb_state[i] <= cmf_pkg::MB_SCHED;
            end
          end
          default: mb_state[i] <= cmf_pkg::MB_EMPTY;
        endcase
      end
    end
  end

  // status flags: hardware set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      tstat <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && wr_addr == cmf_pkg::OFS_TSTAT) begin
          tstat[i*cmf_pkg::TS_STRIDE +: 4] <= tstat[i*cmf_pkg::TS_STRIDE +: 4] &
            ~wr_bits[i*cmf_pkg::TS_STRIDE +: 4];
        end
        if (done_ev[i]) tstat[i*cmf_pkg::TS_STRIDE + cmf_pkg::TS_DONE] <= 1'b1;
        if (done_ev[i] || ok_ev[i]) begin
          tstat[i*cmf_pkg::TS_STRIDE + cmf_pkg::TS_OK] <= ok_ev[i];
        end
        if (arb_ev[i]) tstat[i*cmf_pkg::TS_STRIDE + cmf_pkg::TS_ARB] <= 1'b1;
        if (err_ev[i]) tstat[i*cmf_pkg::TS_STRIDE + cmf_pkg::TS_ERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      for (int w = 0; w < 4; w++) begin
        if (wr_en && is_mb(wr_addr) && wr_addr[5:4] == 2'(i) && wr_addr[3:2] == 2'(w)
            && mb_state[i] == cmf_pkg::MB_EMPTY) begin
          mb_word[i][w] <= merge(mb_word[i][w], wr_data, wr_strb);
        end
      end
      if (tx_active && sof_sample && tx_mailbox == 2'(i)) begin
        mb_word[i][1][31:16] <= timer;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_active <= 1'b0;
      tx_mailbox <= 2'h0;
      tx_id <= 32'h0000_0000;
      tx_len <= 32'h0000_0000;
      tx_data_lo <= 32'h0000_0000;
      tx_data_hi <= 32'h0000_0000;
    end else if (start) begin
      tx_active <= 1'b1;
      tx_mailbox <= win;
      tx_id <= mb_word[win][0];
      tx_len <= mb_word[win][1];
      tx_data_lo <= mb_word[win][2];
      tx_data_hi <= mb_word[win][3];
    end else if (result) begin
      tx_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reception into two fifos
  assign rx_store = rx_frame_ok && rx_filter_pass && !frozen;

  for (genvar f = 0; f < 2; f++) begin : g_fifo
    logic fwr;
    assign fwr = wr_en && wr_addr == (f == 0 ? cmf_pkg::OFS_FIFO0 : cmf_pkg::OFS_FIFO1);
    assign fifo_rel[f] = fwr && wr_bits[cmf_pkg::FR_RELEASE];
    assign fifo_clr_full[f] = fwr && wr_bits[cmf_pkg::FR_FULL];
    assign fifo_clr_ovr[f] = fwr && wr_bits[cmf_pkg::FR_OVR];
    cmf_rx_fifo u_fifo (
      .clk(clk),
      .reset(reset),
      .store(rx_store && rx_fifo_sel == 1'(f)),
      .frame({rx_data_hi, rx_data_lo, sof_stamp, 12'h000, rx_dlc, 3'h0, rx_id}),
      .keep_oldest_select(ctrl[cmf_pkg::CTRL_KEEP]),
      .release_output_slot(fifo_rel[f]),
      .clr_full(fifo_clr_full[f]),
      .clr_overrun(fifo_clr_ovr[f]),
      .pending_irq_enable(ien[f*cmf_pkg::IE_STRIDE]),
      .full_irq_enable(ien[f*cmf_pkg::IE_STRIDE + 1]),
      .overrun_irq_enable(ien[f*cmf_pkg::IE_STRIDE + 2]),
      .head(fifo_head[f]),
      .pending_count(fifo_cnt[f]),
      .full_flag(fifo_full[f]),
      .overrun_flag(fifo_ovr[f]),
      .irq(fifo_irq[f])
    );
  end

  // fifo irqs re-registered so outputs come straight from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_fifo0 <= 1'b0;
      irq_fifo1 <= 1'b0;
    end else begin
      irq_fifo0 <= fifo_irq[0];
      irq_fifo1 <= fifo_irq[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  send_pend_a: assert property (@(posedge clk) disable iff (reset)
    (send_wr[0] && !cancel_wr[0] && mb_state[0] == cmf_pkg::MB_EMPTY)
    |=> mb_state[0] == cmf_pkg::MB_PENDING)
    else $error("request did not pend");
  send_ok_a: assert property (@(posedge clk) disable iff (reset)
    (tx_active && tx_ok && tx_mailbox == 2'h1)
    |=> mb_state[1] == cmf_pkg::MB_EMPTY && tstat[9:8] == 2'h3 && !tx_active)
    else $error("success not reported");
  single_shot_a: assert property (@(posedge clk) disable iff (reset)
    (tx_active && !tx_ok && tx_error && tx_mailbox == 2'h2 && ctrl[cmf_pkg::CTRL_SINGLE])
    |=> mb_state[2] == cmf_pkg::MB_EMPTY && tstat[16] && tstat[19])
    else $error("single attempt retried");
  listen_tx_a: assert property (@(posedge clk) disable iff (reset)
    ctrl[cmf_pkg::CTRL_LISTEN] |=> bus_tx_pin && ($past(tx_active) || !tx_active))
    else $error("listen-only drove or started");
  loop_rx_a: assert property (@(posedge clk) disable iff (reset)
    ctrl[cmf_pkg::CTRL_LOOP] |=> core_rx_bit == $past(core_tx_bit))
    else $error("loop-back path broken");
  mb_lock_a: assert property (@(posedge clk) disable iff (reset)
    (wr_en && wr_addr == 8'h50 && mb_state[1] != cmf_pkg::MB_EMPTY) |=> $stable(mb_word[1][0]))
    else $error("busy mailbox written");
  stamp_tick_a: assert property (@(posedge clk) disable iff (reset)
    (ctrl[cmf_pkg::CTRL_TTIME] && bit_tick && !frozen) |=> timer == $past(timer) + 16'h0001)
    else $error("stamp counter missed a tick");
endmodule
`default_nettype wire

// [rtl/cmf_pkg.sv]
// constants and types shared by the mailbox, fifo and test-mode core
package cmf_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TSTAT = 8'h04;
  localparam logic [7:0] OFS_TREQ = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0C;
  localparam logic [7:0] OFS_FIFO0 = 8'h10;
  localparam logic [7:0] OFS_FIFO1 = 8'h14;
  localparam logic [7:0] OFS_TIMER = 8'h18;
  localparam logic [1:0] OFS_MB_HI = 2'h1;
  localparam logic [2:0] OFS_FO_HI = 3'h4;
  localparam int CTRL_QORDER = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_KEEP = 2;
  localparam int CTRL_FREEZE = 3;
  localparam int CTRL_LISTEN = 4;
  localparam int CTRL_LOOP = 5;
  localparam int CTRL_TTIME = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int TS_DONE = 0;
  localparam int TS_OK = 1;
  localparam int TS_ARB = 2;
  localparam int TS_ERR = 3;
  localparam int TS_STRIDE = 8;
  localparam int TREQ_CANCEL = 4;
  localparam int FR_FULL = 3;
  localparam int FR_OVR = 4;
  localparam int FR_RELEASE = 5;
  localparam int IE_STRIDE = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  typedef enum logic [1:0] {MB_EMPTY, MB_PENDING, MB_SCHED, MB_SEND} cmf_mb_e;
endpackage

// [rtl/cmf_rx_fifo.sv]
// three-frame receive fifo with overrun lock policy and interrupt request
`timescale 1ns/1ps
`default_nettype none
module cmf_rx_fifo (
  input wire logic clk,
  input wire logic reset,
  input wire logic store,
  input wire logic [127:0] frame,
  input wire logic keep_oldest_select,
  input wire logic release_output_slot,
  input wire logic clr_full,
  input wire logic clr_overrun,
  input wire logic pending_irq_enable,
  input wire logic full_irq_enable,
  input wire logic overrun_irq_enable,
  output logic [127:0] head,
  output logic [1:0] pending_count,
  output logic full_flag,
  output logic overrun_flag,
  output logic irq
);
  logic [127:0] mem [3];
  logic rel;
  logic [1:0] cnt_after;
  assign rel = release_output_slot && (pending_count != 2'h0);
  assign cnt_after = rel ? pending_count - 2'h1 : pending_count;
  assign head = mem[0];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_count <= 2'h0;
    end else if (store && cnt_after != cmf_pkg::FIFO_DEPTH) begin
      pending_count <= cnt_after + 2'h1;
    end else begin
      pending_count <= cnt_after;
    end
  end

  always_ff @(posedge clk) begin
    if (rel) begin
      mem[0] <= mem[1];
      mem[1] <= mem[2];
    end
    if (store) begin
      if (cnt_after != cmf_pkg::FIFO_DEPTH) begin
        mem[cnt_after] <= frame;
      end else if (!keep_oldest_select) begin
        mem[2] <= frame;
      end
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      full_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      full_flag <= (full_flag && !clr_full) ||
        (store && cnt_after == 2'h2);
      overrun_flag <= (overrun_flag && !clr_overrun) ||
        (store && cnt_after == cmf_pkg::FIFO_DEPTH);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (pending_irq_enable && pending_count != 2'h0) ||
        (full_irq_enable && full_flag) ||
        (overrun_irq_enable && overrun_flag);
    end
  end

  fifo_ovr_a: assert property (@(posedge clk) disable iff (reset)
    (store && !rel && pending_count == 2'h3) |=> overrun_flag && pending_count == 2'h3)
    else $error("overrun not flagged");
  fifo_full_a: assert property (@(posedge clk) disable iff (reset)
    (store && !rel && pending_count == 2'h2) |=> full_flag && pending_count == 2'h3)
    else $error("full not flagged on third frame");
  fifo_lock_a: assert property (@(posedge clk) disable iff (reset)
    (store && !rel && pending_count == 2'h3 && keep_oldest_select) |=> $stable(mem[2]))
    else $error("locked fifo overwritten");
endmodule
`default_nettype wire

// [tb/cmf_bus_model.sv]
// behavioural protocol engine and bus seen from the core
`timescale 1ns/1ps
`default_nettype none
module cmf_bus_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_active,
  output logic bus_idle,
  output logic tx_ok,
  output logic bus_rx_pin
);
  logic [4:0] cnt;
  assign bus_idle = 1'b1;
  // released bus rests recessive
  assign bus_rx_pin = 1'b1;
  // slow answer leaves room to poke a busy mailbox
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 5'h00;
      tx_ok <= 1'b0;
    end else begin
      cnt <= (tx_active && !tx_ok) ? cnt + 5'h01 : 5'h00;
      tx_ok <= tx_active && (cnt == 5'h14);
    end
  end
endmodule
`default_nettype wire

// [tb/cmf_core_bench.sv]
// register-level bench for the mailbox, fifo and test-mode core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) if ((a) !== (e)) fail(32'(a), 32'(e)); else n_tests++;
module cmf_core_bench;
  logic clk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, bit_tick = 0, sof_sample = 0, core_tx_bit = 1;
  logic tx_arb_lost = 0, tx_error = 0, rx_frame_ok = 0, rx_filter_pass = 0, rx_fifo_sel = 0;
  logic debug_halt = 0, debug_stop_first_controller = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rx_data_lo = 32'h0, rx_data_hi = 32'h0, v, t1;
  logic [31:0] s_axi_rdata, tx_id, tx_len, tx_data_lo, tx_data_hi;
  logic [3:0] s_axi_wstrb = 4'hF, rx_dlc = 4'h0;
  logic [28:0] rx_id = 29'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_mailbox, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_rx_bit, ignore_ack, tx_active, bus_idle, tx_ok, bus_rx_pin, bus_tx_pin;
  logic frozen, irq_fifo0, irq_fifo1;
  int n_errors = 0, n_tests = 0, cyc = 0;
  cmf_core cmf_core_i (.*);
  cmf_bus_model cmf_bus_model_i (.*);
  always #2 clk = ~clk;
  always @(posedge clk) bit_tick <= ~bit_tick;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic fail(input logic [31:0] a, input logic [31:0] e);
    n_errors++;
    n_tests++;
    $display("wrong value at %0t: %h expected %h", $time, a, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // bready stays high between writes so it is never set twice in one step
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk); while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  task automatic wt(input logic lv);
    while (tx_active !== lv) @(posedge clk);
  endtask
  task automatic st(input int i);
    rx_id <= 29'(i);
    rx_dlc <= 4'(i);
    rx_data_lo <= 32'(i);
    rx_frame_ok <= 1'b1;
    rx_filter_pass <= 1'b1;
    @(posedge clk);
    rx_frame_ok <= 1'b0;
    rx_filter_pass <= 1'b0;
    @(posedge clk);
  endtask
  // settle three cycles: pin routing adds one
  task automatic md(input logic [31:0] c, input logic p, input logic x);
    wr(cmf_pkg::OFS_CTRL, c);
    repeat (3) @(posedge clk);
    `CHK(bus_tx_pin, p)
    `CHK(core_rx_bit, x)
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rc(cmf_pkg::OFS_CTRL, 32'h0);
    rd(8'hFC);
    `CHK(r, cmf_pkg::RESP_SLVERR)
    $display("register test done");
    wr(8'h40, 32'h123);
    wr(cmf_pkg::OFS_TREQ, 32'h1);
    wt(1'b1);
    `CHK(tx_id, 32'h123)
    wr(8'h40, 32'h55);
    wt(1'b0);
    rc(8'h40, 32'h123);
    rc(cmf_pkg::OFS_TSTAT, 32'h3);
    wr(8'h40, 32'h5);
    wr(8'h50, 32'h3);
    wr(cmf_pkg::OFS_TREQ, 32'h3);
    wt(1'b1);
    `CHK(tx_mailbox, 2'h1)
    wt(1'b0);
    wt(1'b1);
    `CHK(tx_mailbox, 2'h0)
    wt(1'b0);
    wr(cmf_pkg::OFS_CTRL, 32'h2);
    wr(8'h60, 32'h9);
    wr(cmf_pkg::OFS_TREQ, 32'h4);
    wt(1'b1);
    tx_error <= 1'b1;
    @(posedge clk);
    tx_error <= 1'b0;
    wt(1'b0);
    rc(cmf_pkg::OFS_TSTAT, 32'h0009_0303);
    rc(cmf_pkg::OFS_TREQ, 32'h0);
    wr(cmf_pkg::OFS_TSTAT, 32'h000F_0F0F);
    // listen-only holds the queue back so request order can be seen
    wr(cmf_pkg::OFS_CTRL, 32'h11);
    wr(8'h40, 32'h2);
    wr(8'h50, 32'h1);
    wr(8'h60, 32'h0);
    wr(cmf_pkg::OFS_TREQ, 32'h1);
    wr(cmf_pkg::OFS_TREQ, 32'h2);
    wr(cmf_pkg::OFS_TREQ, 32'h4);
    wr(8'h50, 32'h77);
    wr(cmf_pkg::OFS_TREQ, 32'h40);
    rc(cmf_pkg::OFS_TREQ, 32'h6);
    rc(cmf_pkg::OFS_TSTAT, 32'h0001_0000);
    rc(8'h50, 32'h1);
    wr(cmf_pkg::OFS_CTRL, 32'h1);
    wt(1'b1);
    `CHK(tx_mailbox, 2'h0)
    wt(1'b0);
    wt(1'b1);
    `CHK(tx_mailbox, 2'h1)
    wt(1'b0);
    $display("transmit test done");
    wr(cmf_pkg::OFS_IEN, 32'h1);
    for (int i = 1; i < 5; i++) st(i);
    `CHK(irq_fifo0, 1'b1)
    rc(cmf_pkg::OFS_FIFO0, 32'h1B);
    rc(8'h80, 32'h1);
    wr(cmf_pkg::OFS_FIFO0, 32'h20);
    rc(8'h80, 32'h2);
    wr(cmf_pkg::OFS_FIFO0, 32'h20);
    rc(8'h80, 32'h4);
    wr(cmf_pkg::OFS_CTRL, 32'h4);
    wr(cmf_pkg::OFS_IEN, 32'h20);
    rx_fifo_sel <= 1'b1;
    for (int i = 5; i < 9; i++) st(i);
    repeat (2) @(posedge clk);
    `CHK(irq_fifo1, 1'b1)
    rc(cmf_pkg::OFS_FIFO1, 32'h1B);
    wr(cmf_pkg::OFS_FIFO1, 32'h20);
    wr(cmf_pkg::OFS_FIFO1, 32'h20);
    rc(8'h90, 32'h7);
    $display("fifo test done");
    core_tx_bit <= 1'b0;
    md(32'h10, 1'b1, 1'b0);
    wr(8'h40, 32'h7);
    wr(cmf_pkg::OFS_TREQ, 32'h1);
    repeat (8) @(posedge clk);
    `CHK(tx_active, 1'b0)
    md(32'h20, 1'b0, 1'b0);
    `CHK(ignore_ack, 1'b1)
    md(32'h30, 1'b1, 1'b0);
    // bit_tick toggles every cycle: 22 edges between the two samples give 11 ticks
    wr(cmf_pkg::OFS_CTRL, 32'h40);
    rd(cmf_pkg::OFS_TIMER);
    t1 = v;
    repeat (20) @(posedge clk);
    rd(cmf_pkg::OFS_TIMER);
    `CHK(v - t1, 32'hB)
    debug_halt <= 1'b1;
    debug_stop_first_controller <= 1'b1;
    wr(cmf_pkg::OFS_CTRL, 32'h48);
    rd(cmf_pkg::OFS_TIMER);
    t1 = v;
    repeat (20) @(posedge clk);
    rc(cmf_pkg::OFS_TIMER, t1);
    `CHK(frozen, 1'b1)
    $display("mode test done");
    finish_test();
  end
endmodule
`default_nettype wire
